// [cpcr_pkg.sv]
// Constants for the codec power configuration register bank.
// Assumes an 8-bit register address and 8-bit data on the control port.
package cpcr_pkg;
  // Port widths and channel count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 4;

  // Register addresses
  localparam logic [7:0] POWER_CONFIG_ADDR = 8'h78;  // power_config
  localparam logic [7:0] DEV_STS_ADDR = 8'h79;  // device_status_zero
  localparam logic [7:0] DYN_CFG_ADDR = 8'h77;  // dynamic_power_config

  // Reset values
  localparam logic [7:0] POWER_CONFIG_RST = 8'h00;
  localparam logic [7:0] DYN_CFG_RST = 8'h00;
  localparam logic [7:0] RDATA_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // power_config field positions
  localparam int PWR_RECORD_BIT   = 7;
  localparam int PWR_PLAYBACK_BIT = 6;
  localparam int PWR_BIAS_BIT     = 5;
  localparam int PWR_UAD_BIT      = 3;
  localparam int PWR_VAD_BIT      = 2;
  localparam int PWR_UAG_BIT      = 1;
  // Writable bits; bits 4 and 0 are read-only zero
  localparam logic [7:0] PWR_WR_MASK = 8'hee;

  // dynamic_power_config field positions
  localparam int DYN_EN_BIT    = 5;
  localparam int DYN_SPAN_BIT  = 4;
  localparam int DYN_SPLIT_BIT = 3;
  // Writable bits; bits 2..0 (and unknown 7..6) read as zero
  localparam logic [7:0] DYN_WR_MASK = 8'h38;

  // Status layout: record ch1 at bit 7, playback ch1 at bit 3
  localparam int STS_REC_TOP = 7;
  localparam int STS_PB_TOP  = 3;

  // Channels covered by dynamic control with span field at zero
  localparam int SPAN_NARROW_CH = 2;
endpackage : cpcr_pkg

// [cpcr_chan_gate.sv]
// Per-channel power state flops behind one master power field.
// Assumes enables and hold terms come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cpcr_chan_gate #(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Control
  input  wire logic         master_on,
  input  wire logic [N-1:0] chan_enable,
  input  wire logic [N-1:0] chan_hold,
  // Channel power state
  output var  logic [N-1:0] power_q
);

  // One flop per channel; master off wins over hold
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      power_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (!master_on) begin
          power_q[i] <= 1'b0;             // Master off: all down
        end else if (!chan_hold[i]) begin
          power_q[i] <= chan_enable[i];   // Only enabled channels up
        end
      end
    end
  end

endmodule : cpcr_chan_gate
`default_nettype wire

// [cpcr_regs.sv]
// Power configuration, dynamic power configuration and status registers.
// Assumes a single-cycle write/read strobe from the control interface.
// How it works
// - Record field off downs all; on ups enabled.
// - Playback field off downs all; on ups enabled.
// - Mic bias follows its power field.
// - Ultrasound detection runs only while enabled.
// - Voice detection runs only while enabled.
// - Auxiliary ultrasound function runs only while enabled.
// - Power register unused bits read-only zero.
// - Span field picks channels 1-2 or 1-4.
// - Split field selects separate modulator/PDM clocks.
// - Dynamic register low three bits read zero.
// - Power register at 0x78, resets to zero.
// - Read-only status register at 0x79.
// - Dynamic mode allows per-channel changes during playback.
// - Status low nibble shows playback channel power.
`timescale 1ns/10ps
`default_nettype none
module cpcr_regs
  import cpcr_pkg::*;
#(
  parameter int CH = cpcr_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // Control interface register port
  input  wire logic [cpcr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cpcr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output var  logic [cpcr_pkg::DATA_W-1:0] reg_rdata_q,
  // Individual channel enables from other registers
  input  wire logic [CH-1:0]               record_ch_enable,
  input  wire logic [CH-1:0]               playback_ch_enable,
  // Channel power state
  output logic [CH-1:0]                    record_ch_power_q,
  output logic [CH-1:0]                    playback_ch_power_q,
  // Global power and algorithm controls
  output logic                             record_power_on,
  output logic                             playback_power_on,
  output logic                             mic_bias_power_on,
  output logic                             ultrasound_detect_enable,
  output logic                             voice_detect_enable,
  output logic                             ultrasound_aux_enable,
  // Dynamic playback controls
  output logic                             playback_dynamic_power_enable,
  output logic                             playback_dynamic_channel_span,
  output logic                             dynamic_power_split_mod_clocks
);
  import cpcr_pkg::*;

  logic [DATA_W-1:0] pwr_q;        // power_config storage
  logic [DATA_W-1:0] dyn_q;        // dynamic_power_config storage
  logic [DATA_W-1:0] status;       // device_status_zero view
  logic [DATA_W-1:0] rdata_d;      // Read mux
  logic [CH-1:0]     pb_hold;      // Playback channels frozen
  logic [CH-1:0]     rec_hold;     // Record never frozen
  logic              pb_running;   // Any playback channel up
  logic              wr_pwr;       // Write hits power_config
  logic              wr_dyn;       // Write hits dynamic_power_config

  // Address decode
  assign wr_pwr = reg_write && (reg_addr == POWER_CONFIG_ADDR);
  assign wr_dyn = reg_write && (reg_addr == DYN_CFG_ADDR);

  // power_config: reserved bits never stored, so read back zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwr_q <= POWER_CONFIG_RST;
    end else if (wr_pwr) begin
      pwr_q <= reg_wdata & PWR_WR_MASK;
    end
  end

  // dynamic_power_config: low bits stay zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dyn_q <= DYN_CFG_RST;
    end else if (wr_dyn) begin
      dyn_q <= reg_wdata & DYN_WR_MASK;
    end
  end

  // Global controls straight from the stored fields
  assign record_power_on          = pwr_q[PWR_RECORD_BIT];
  assign playback_power_on        = pwr_q[PWR_PLAYBACK_BIT];
  assign mic_bias_power_on        = pwr_q[PWR_BIAS_BIT];
  assign ultrasound_detect_enable = pwr_q[PWR_UAD_BIT];
  assign voice_detect_enable      = pwr_q[PWR_VAD_BIT];
  assign ultrasound_aux_enable    = pwr_q[PWR_UAG_BIT];

  // Dynamic controls
  assign playback_dynamic_power_enable  = dyn_q[DYN_EN_BIT];
  assign playback_dynamic_channel_span  = dyn_q[DYN_SPAN_BIT];
  // Clock split only shapes the sequencing elsewhere
  assign dynamic_power_split_mod_clocks = dyn_q[DYN_SPLIT_BIT];

  // Freeze terms: while playback runs, a channel may change only if
  // dynamic mode is on and the channel lies inside the span. Freezing
  // rather than erroring keeps an unsupported change harmless.
  assign pb_running = |playback_ch_power_q;
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      pb_hold[i] = pb_running &&
                   !(playback_dynamic_power_enable &&
                     (playback_dynamic_channel_span ||
                      (i < SPAN_NARROW_CH)));
    end
  end
  assign rec_hold = '0;

  // Record channel power
  cpcr_chan_gate #(
    .N (CH)
  ) u_record_gate (
    .clock       (clock),
    .reset       (reset),
    .master_on   (record_power_on),
    .chan_enable (record_ch_enable),
    .chan_hold   (rec_hold),
    .power_q     (record_ch_power_q)
  );

  // Playback channel power
  cpcr_chan_gate #(
    .N (CH)
  ) u_playback_gate (
    .clock       (clock),
    .reset       (reset),
    .master_on   (playback_power_on),
    .chan_enable (playback_ch_enable),
    .chan_hold   (pb_hold),
    .power_q     (playback_ch_power_q)
  );

  // Status view: channel 1 in the top bit of each nibble
  always_comb begin
    status = '0;
    for (int i = 0; i < CH; i++) begin
      status[STS_REC_TOP - i] = record_ch_power_q[i];
      status[STS_PB_TOP - i]  = playback_ch_power_q[i];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      POWER_CONFIG_ADDR: rdata_d = pwr_q;
      DEV_STS_ADDR: rdata_d = status;
      DYN_CFG_ADDR: rdata_d = dyn_q;
      default:      rdata_d = UNMAPPED_RD;
    endcase
  end

  // Read data registered one cycle after the strobe, then held
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= RDATA_RST;
    end else if (reg_read) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // Checks

  chk_record_off: assert property (@(posedge clock) disable iff (reset)
    !record_power_on |=> (record_ch_power_q == '0))
    else $error("record channel up while record field off");

  chk_record_on: assert property (@(posedge clock) disable iff (reset)
    record_power_on |=> (record_ch_power_q == $past(record_ch_enable)))
    else $error("record channels do not match enables");

  chk_playback_off: assert property (@(posedge clock) disable iff (reset)
    !playback_power_on |=> (playback_ch_power_q == '0))
    else $error("playback channel up while playback field off");

  chk_playback_idle_on: assert property (@(posedge clock) disable iff (reset)
    (playback_power_on && !pb_running)
      |=> (playback_ch_power_q == $past(playback_ch_enable)))
    else $error("idle playback did not take enables");

  chk_ctrl_write: assert property (@(posedge clock) disable iff (reset)
    wr_pwr |=> ({mic_bias_power_on, ultrasound_detect_enable,
                 voice_detect_enable, ultrasound_aux_enable} ==
                {$past(reg_wdata[PWR_BIAS_BIT]), $past(reg_wdata[PWR_UAD_BIT]),
                 $past(reg_wdata[PWR_VAD_BIT]), $past(reg_wdata[PWR_UAG_BIT])}))
    else $error("power_config write not applied next edge");

  chk_pwr_reserved: assert property (@(posedge clock) disable iff (reset)
    wr_pwr |=> ((pwr_q & ~PWR_WR_MASK) == '0))
    else $error("power_config reserved bit set");

  chk_dyn_write: assert property (@(posedge clock) disable iff (reset)
    wr_dyn |=> (dyn_q == ($past(reg_wdata) & DYN_WR_MASK)) && (dyn_q[2:0] == 3'h0))
    else $error("dynamic_power_config write wrong");

  chk_pb_freeze: assert property (@(posedge clock) disable iff (reset)
    (playback_power_on && pb_running && !playback_dynamic_power_enable)
      |=> $stable(playback_ch_power_q))
    else $error("playback changed during playback without dynamic mode");

  chk_span_limit: assert property (@(posedge clock) disable iff (reset)
    (playback_power_on && pb_running && playback_dynamic_power_enable &&
     !playback_dynamic_channel_span)
      |=> $stable(playback_ch_power_q[CH-1:SPAN_NARROW_CH]))
    else $error("channel outside span changed dynamically");

  chk_status_read: assert property (@(posedge clock) disable iff (reset)
    (reg_read && reg_addr == DEV_STS_ADDR)
      |=> (reg_rdata_q[STS_PB_TOP] == $past(playback_ch_power_q[0])) &&
          (reg_rdata_q[STS_REC_TOP] == $past(record_ch_power_q[0])))
    else $error("status read does not show channel power");

  // Main scenarios
  cov_dyn_change: cover property (@(posedge clock) disable iff (reset)
    pb_running && playback_dynamic_power_enable ##1 $changed(playback_ch_power_q));
  cov_record_up: cover property (@(posedge clock) disable iff (reset)
    $rose(record_power_on) ##1 (record_ch_power_q != '0));
  cov_status_rd: cover property (@(posedge clock) disable iff (reset)
    reg_read && (reg_addr == DEV_STS_ADDR) && pb_running);

endmodule : cpcr_regs
`default_nettype wire

// [cpcr_host_model.sv]
// Host control-port model: issues single-cycle write and read strobes.
// Assumes the register bank samples its strobes on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module cpcr_host_model (
  // Clock
  input  wire logic                        clock,
  // Register port toward the device
  output var  logic [cpcr_pkg::ADDR_W-1:0] reg_addr,
  output var  logic [cpcr_pkg::DATA_W-1:0] reg_wdata,
  output var  logic                        reg_write,
  output var  logic                        reg_read,
  input  wire logic [cpcr_pkg::DATA_W-1:0] reg_rdata_q
);
  import cpcr_pkg::*;

  // Idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  // One write strobe; a well-behaved host writes zero to reserved bits
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input bit raw);
    logic [7:0] keep;
    keep = (addr == POWER_CONFIG_ADDR) ? PWR_WR_MASK :
           (addr == DYN_CFG_ADDR) ? DYN_WR_MASK : 8'hff;
    @(negedge clock);
    reg_addr  = addr;
    reg_wdata = raw ? data : (data & keep);  // Raw only when a test means to misbehave
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    // Released lines flip so stale values never look valid
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : write_reg

  // One read strobe; data is taken after the answering edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    reg_addr = addr;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    data     = reg_rdata_q;
    reg_addr = ~reg_addr;
  endtask : read_reg
endmodule : cpcr_host_model
`default_nettype wire

// [codec_power_config_regs_bench.sv]
// Self-checking bench for the codec power configuration register bank.
// Assumes the host model drives the register port; channel enables come from here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %0t: mismatch got %h expected %h", $time, got, exp); end end
module codec_power_config_regs_bench;
  import cpcr_pkg::*;
  logic       clock;           // Bench clock
  logic       reset;           // Async reset, active high
  logic [7:0] reg_addr;        // Register port
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata_q;
  logic [3:0] rec_en;          // Channel enables from other registers
  logic [3:0] pb_en;
  logic [3:0] rec_pwr;         // Channel power state
  logic [3:0] pb_pwr;
  logic [5:0] pwr_vec;         // power_config outputs 7,6,5,3,2,1
  logic [2:0] dyn_vec;         // dynamic_power_config outputs 5,4,3
  logic [7:0] d;               // Read data scratch
  int         err_count;
  int         total_checks;

  // Device under test
  cpcr_regs #(.CH(4)) i_dut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .record_ch_enable(rec_en), .playback_ch_enable(pb_en),
    .record_ch_power_q(rec_pwr), .playback_ch_power_q(pb_pwr),
    .record_power_on(pwr_vec[5]), .playback_power_on(pwr_vec[4]),
    .mic_bias_power_on(pwr_vec[3]), .ultrasound_detect_enable(pwr_vec[2]),
    .voice_detect_enable(pwr_vec[1]), .ultrasound_aux_enable(pwr_vec[0]),
    .playback_dynamic_power_enable(dyn_vec[2]),
    .playback_dynamic_channel_span(dyn_vec[1]),
    .dynamic_power_split_mod_clocks(dyn_vec[0]));

  // Host side of the control port
  cpcr_host_model i_host (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q));

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Counts, verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Let channel flops follow one more edge
  task automatic settle();
    @(negedge clock);
  endtask : settle

  // Watchdog against a hung run
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    $display("ERROR %0t: run did not finish", $time);
    summarize();
  end

  // Main sequence
  initial begin
    err_count = 0;
    total_checks = 0;
    reset = 1'b1;
    rec_en = 4'h0;
    pb_en = 4'h0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    i_host.read_reg(POWER_CONFIG_ADDR, d); `CHK(d, 8'h00)
    i_host.read_reg(DEV_STS_ADDR, d); `CHK(d, 8'h00)
    i_host.read_reg(DYN_CFG_ADDR, d); `CHK(d, 8'h00)
    // Each power field alone drives only its own output on the next edge
    foreach (pwr_vec[i]) begin
      i_host.write_reg(POWER_CONFIG_ADDR, 8'h02 << (i + (i > 2)), 1'b0);
      `CHK(pwr_vec, 6'h01 << i)
    end
    rec_en = 4'h1;
    pb_en = 4'h3;
    i_host.write_reg(POWER_CONFIG_ADDR, 8'hff, 1'b1);
    `CHK(pwr_vec, 6'h3f)
    settle();
    `CHK({rec_pwr, pb_pwr}, 8'h13)
    i_host.read_reg(POWER_CONFIG_ADDR, d); `CHK(d, 8'hee)
    i_host.read_reg(DEV_STS_ADDR, d); `CHK(d, 8'h8c)
    // Dynamic control off: no channel change while playback runs; on, channels inside the span change
    pb_en = 4'hf;
    settle();
    settle();
    `CHK(pb_pwr, 4'h3)
    i_host.write_reg(DYN_CFG_ADDR, 8'h20, 1'b0);
    pb_en = 4'he;
    settle();
    settle();
    `CHK(pb_pwr, 4'h2)
    i_host.write_reg(DYN_CFG_ADDR, 8'h30, 1'b0);
    settle();
    `CHK(pb_pwr, 4'he)
    i_host.write_reg(DYN_CFG_ADDR, 8'hff, 1'b1);
    `CHK(dyn_vec, 3'h7)
    i_host.read_reg(DYN_CFG_ADDR, d); `CHK(d, 8'h38)
    i_host.read_reg(DEV_STS_ADDR, d); `CHK(d, 8'h87)
    i_host.write_reg(DEV_STS_ADDR, 8'hff, 1'b1);
    i_host.read_reg(DEV_STS_ADDR, d); `CHK(d, 8'h87)
    i_host.read_reg(8'h55, d); `CHK(d, 8'h00)
    // Playback field off downs all playback, record stays
    i_host.write_reg(POWER_CONFIG_ADDR, 8'h80, 1'b0);
    settle();
    `CHK({rec_pwr, pb_pwr, pwr_vec[3]}, 9'h020)
    i_host.write_reg(POWER_CONFIG_ADDR, 8'h00, 1'b0);
    settle();
    `CHK(rec_pwr, 4'h0)
    // Reset in mid-run clears everything
    i_host.write_reg(POWER_CONFIG_ADDR, 8'hee, 1'b0);
    settle();
    reset = 1'b1;
    @(negedge clock);
    `CHK({rec_pwr, pb_pwr, pwr_vec, dyn_vec}, 17'h0)
    reset = 1'b0;
    i_host.read_reg(POWER_CONFIG_ADDR, d); `CHK(d, 8'h00)
    summarize();
  end
endmodule : codec_power_config_regs_bench
`default_nettype wire
